// ==== pkg/dmp_pkg.sv ====
// constants and types for the dual-modulus prescaler
package dmp_pkg;

  // ==========================================================
  // divide ratios
  localparam int unsigned LOW_PAIR_BASE  = 32;
  localparam int unsigned HIGH_PAIR_BASE = 64;
  localparam int unsigned SWALLOW_EXTRA  = 1;
  localparam int unsigned CNT_W          = 7;
  localparam int unsigned CNT_STEP       = 1;
  localparam int unsigned MIN_RATIO      = 2;

  // ==========================================================
  // edge polarity variants
  typedef enum logic
  {
    DMP_EDGE_RISE,
    DMP_EDGE_FALL
  } dmp_edge_t;

  // ==========================================================
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

endpackage

// ==== core/dmp_prescaler.sv ====
// dual-modulus prescaler core: divides the input clock by 32/33 or 64/65
`timescale 1ns/100ps
// Behaviour
// - range select high gives the 32/33 pair, low gives 64/65
// - modulus select high picks the lower ratio, low adds one more cycle
// - rising-edge variant: the output period starts with a rising edge
// - falling-edge variant: each output period after the first starts with a falling edge (the output resets low)
module dmp_prescaler #(
  // which edge of the divided output marks the start of a period
  parameter dmp_pkg::dmp_edge_t EDGE_MODE = dmp_pkg::DMP_EDGE_RISE,
  // base ratio of the pair picked with range select high, and with it low
  parameter int unsigned        LOW_PAIR  = dmp_pkg::LOW_PAIR_BASE,
  parameter int unsigned        HIGH_PAIR = dmp_pkg::HIGH_PAIR_BASE
)(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic clk_en_i,
  input  wire logic ratio_range_select_i,
  input  wire logic modulus_select_i,
  output logic      div_out_o
);

  // ==========================================================
  // elaboration checks
  // the largest ratio, swallow cycle included, must fit the down-counter
  if (HIGH_PAIR + dmp_pkg::SWALLOW_EXTRA >= (1 << dmp_pkg::CNT_W))
  begin : g_bad_width
    $error("counter too narrow for the largest ratio");
  end
  // the lower pair goes through the same counter and length register
  if (LOW_PAIR + dmp_pkg::SWALLOW_EXTRA >= (1 << dmp_pkg::CNT_W))
  begin : g_bad_low
    $error("counter too narrow for the lower pair");
  end
  // a period shorter than two cycles leaves no room for both output levels
  if (LOW_PAIR < dmp_pkg::MIN_RATIO || HIGH_PAIR < dmp_pkg::MIN_RATIO)
  begin : g_bad_short
    $error("ratio too small to form a two-level output period");
  end

  // ==========================================================
  // constants sized to the counter
  localparam int unsigned CW = dmp_pkg::CNT_W;

  localparam logic [CW-1:0] LOW_BASE  = CW'(LOW_PAIR);
  localparam logic [CW-1:0] HIGH_BASE = CW'(HIGH_PAIR);
  localparam logic [CW-1:0] EXTRA     = CW'(dmp_pkg::SWALLOW_EXTRA);
  localparam logic [CW-1:0] ONE       = CW'(dmp_pkg::CNT_STEP);
  localparam logic [CW-1:0] ZERO      = dmp_pkg::CNT_RST;             // period start marker
  // level that the output takes for the first part of each period
  localparam logic          ACT_LVL   = (EDGE_MODE == dmp_pkg::DMP_EDGE_RISE);

  // ==========================================================
  // state
  logic [dmp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;       // cycles left in this period, minus one
  logic [dmp_pkg::CNT_W-1:0] len_r, len_nxt;       // length of current period
  logic                      out_r, out_nxt;
  logic [dmp_pkg::CNT_W-1:0] ratio;
  // checker helper: enabled edges seen since the last period start
  logic [dmp_pkg::CNT_W-1:0] seen_r, seen_nxt;
  logic                      armed_r, armed_nxt;   // a whole period has been started

  // ratio chosen from range and modulus select
  always_comb
  begin
    ratio = ratio_range_select_i ? LOW_BASE : HIGH_BASE;
    if (!modulus_select_i)
    begin
      ratio = ratio + EXTRA;
    end
  end

  // next-state: count down; reload at end of period with a fresh ratio
  always_comb
  begin
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    out_nxt = out_r;
    if (clk_en_i)
    begin
      if (cnt_r == dmp_pkg::CNT_RST)
      begin
        cnt_nxt = ratio - ONE;
        len_nxt = ratio;
        out_nxt = ACT_LVL;
      end
      else
      begin
        cnt_nxt = cnt_r - ONE;
        // output returns to idle level halfway through the period
        if (cnt_r == (len_r >> 1))
        begin
          out_nxt = ~ACT_LVL;
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= dmp_pkg::CNT_RST;
      len_r <= HIGH_BASE;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      out_r <= out_nxt;
    end
  end

  assign div_out_o = out_r;

  // ==========================================================
  // period measurement for the checks below
  // counts enabled edges from one period start to the next, so that the
  // assertions can hold the measured length against the loaded ratio;
  // the first start after reset closes no period, so armed_r keeps it out of the check
  always_comb
  begin
    seen_nxt  = seen_r;
    armed_nxt = armed_r;
    if (clk_en_i)
    begin
      if (cnt_r == ZERO)
      begin
        seen_nxt  = ONE;                                             // this edge opens a period
        armed_nxt = 1'b1;
      end
      else
      begin
        seen_nxt = seen_r + ONE;
      end
    end
  end

  // measurement registers; cleared with the divider so no stale count survives
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seen_r  <= ZERO;
      armed_r <= 1'b0;
    end
    else
    begin
      seen_r  <= seen_nxt;
      armed_r <= armed_nxt;
    end
  end

  // ==========================================================
  // assertions
  a_ratio_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r == dmp_pkg::CNT_RST) |=>
      (len_r == ($past(ratio_range_select_i) ? LOW_BASE : HIGH_BASE)
               + ($past(modulus_select_i) ? ZERO : EXTRA)))
    else $error("period length does not match range select");

  a_modulus_extra: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r == dmp_pkg::CNT_RST && !modulus_select_i) |=>
      (len_r[0] == 1'b1))
    else $error("modulus low did not add one cycle");

  a_active_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r == dmp_pkg::CNT_RST) |=> (out_r == ACT_LVL))
    else $error("period did not start on the active level");

  a_edge_only_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (out_r != ACT_LVL) ##1 (out_r == ACT_LVL) |->
      ($past(cnt_r) == dmp_pkg::CNT_RST))
    else $error("active edge away from period start");

  a_count_down: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r != dmp_pkg::CNT_RST) |=> (cnt_r == $past(cnt_r) - ONE))
    else $error("counter did not step down");

  a_freeze_en: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !clk_en_i |=> $stable(cnt_r) && $stable(len_r) && $stable(out_r))
    else $error("state moved with enable low");

  a_reload_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r == dmp_pkg::CNT_RST) |=> (cnt_r == len_r - ONE))
    else $error("reload value wrong");

  a_idle_half: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r != dmp_pkg::CNT_RST && cnt_r == (len_r >> 1)) |=>
      (out_r == ~ACT_LVL))
    else $error("output not back to idle at half period");

  // a period lasts exactly the ratio loaded at its start, counted in enabled edges
  a_period_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clk_en_i && cnt_r == ZERO && armed_r) |-> (seen_r == len_r))
    else $error("measured period differs from the loaded ratio");

  // range and modulus changes inside a period must not alter its length
  a_length_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!clk_en_i || cnt_r != ZERO) |=> $stable(len_r))
    else $error("period length changed inside a period");

  // the output only moves at a period start or at the half-period point
  a_level_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!clk_en_i || (cnt_r != ZERO && cnt_r != (len_r >> 1))) |=> $stable(out_r))
    else $error("output moved away from a period start or half point");

  // ==========================================================
  // coverage of the four ratios and of a start held back by the enable
  c_start_frozen: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    !clk_en_i && cnt_r == ZERO && armed_r);
  c_div32: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && cnt_r == dmp_pkg::CNT_RST && ratio_range_select_i && modulus_select_i);
  c_div33: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && cnt_r == dmp_pkg::CNT_RST && ratio_range_select_i && !modulus_select_i);
  c_div64: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && cnt_r == dmp_pkg::CNT_RST && !ratio_range_select_i && modulus_select_i);
  c_div65: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && cnt_r == dmp_pkg::CNT_RST && !ratio_range_select_i && !modulus_select_i);

endmodule

// ==== tb/dmp_synth_model.sv ====
// synthesizer-side model that steers the modulus select once per output period
`timescale 1ns/100ps
module dmp_synth_model (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic div_i,
  output logic      modulus_select_o
);
  logic prev_r = 1'b0;
  logic mod_r  = 1'b1;                       // start on the lower ratio
  assign modulus_select_o = mod_r;
  // pick a new modulus just after each period start, so it acts on the next one
  always @(posedge clk_sys_i)
  begin
    prev_r <= div_i;
    if (!rst_i && div_i && !prev_r)
      #1 mod_r = 1'($urandom_range(1));
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: measures every output period between two seen period starts against the selected ratio
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin errors++; \
  $display("unexpected %s expected %0d seen %0d", nm, ex, got); end end
module testbench;
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       clk_en_i  = 1'b1;
  logic       range_r   = 1'b1;
  logic       mod_w;
  wire  [1:0] div_w;                            // [0] rising-edge variant, [1] falling-edge
  wire  [1:0] start_w;                          // a period start seen on each variant
  int         errors = 0;
  int         samples_checked = 0;
  // print the counts and the verdict, then stop
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // the partner model follows the rising-edge variant; both variants share its inputs
  dmp_synth_model u_dmp_synth_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .div_i(div_w[0]),
    .modulus_select_o(mod_w));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // flip the range strap now and then, just after a period start
  always @(posedge clk_sys_i)
    if (start_w[0])
    begin
      #1 if ($urandom_range(3) == 0) range_r = ~range_r;
    end
  // one prescaler per edge variant, each with its own notes and period checker
  for (genvar g = 0; g < 2; g++)
  begin : g_var
    localparam logic FALL = (g == 1);
    logic       prev_r    = 1'b0;
    logic       started_r = 1'b0;
    logic [7:0] cnt_r     = 8'h00;
    logic [7:0] exp_v;
    logic [7:0] exp_q[$];
    dmp_prescaler #(
      .EDGE_MODE(FALL ? dmp_pkg::DMP_EDGE_FALL : dmp_pkg::DMP_EDGE_RISE)
    ) u_dmp_prescaler (
      .clk_sys_i           (clk_sys_i),
      .rst_i               (rst_i),
      .clk_en_i            (clk_en_i),
      .ratio_range_select_i(range_r),
      .modulus_select_i    (mod_w),
      .div_out_o           (div_w[g])
    );
    // a period start is the output leaving its idle level
    assign start_w[g] = (div_w[g] != prev_r) && (div_w[g] != FALL);
    // note the ratio that the period just started was given
    always @(posedge clk_sys_i)
      if (start_w[g])
        exp_q.push_back((range_r ? 8'h20 : 8'h40) + {7'h00, !mod_w});
    // count enabled edges between period starts and compare
    always @(posedge clk_sys_i)
    begin
      prev_r <= div_w[g];
      if (start_w[g])
      begin
        if (started_r)
        begin
          exp_v = exp_q.pop_front();
          `CHECK("period", exp_v, cnt_r)
        end
        started_r <= 1'b1;
        cnt_r     <= {7'h00, clk_en_i};
      end
      else
        cnt_r <= cnt_r + {7'h00, clk_en_i};
      if (cnt_r > 8'hC8)
      begin
        errors++;
        conclude();
      end
    end
  end
  // reset, then run with the clock enable dropping now and then
  initial
  begin
    void'($urandom(32'hC514));
    repeat (4) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    repeat (20000) @(posedge clk_sys_i) #1 clk_en_i = ($urandom_range(7) != 0);
    conclude();
  end
endmodule
